// ==== pssr_dev.sv ====
// Device end: PWM and supply status register bank behind the serial link
`timescale 1ns/10ps
`default_nettype none
module pssr_dev #(
	parameter int SHORT_CYCLES = pssr_pkg::SHORT_CYCLES
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	pssr_link_if.dev link,
	input wire logic soft_reset_i,
	input wire pssr_pkg::pssr_mode_t dev_mode_i,
	input wire logic main_on_i,
	input wire logic reset_output_pin_i,
	input wire logic [pssr_pkg::DET_W-1:0] detect_i,
	input wire logic [7:0] pwm_one_duty_i,
	output logic [1:0] pwm_o,
	output logic failsafe_o
);

	localparam int CW = $clog2(SHORT_CYCLES + 1);
	localparam logic [CW-1:0] SHORT_LIM = CW'(SHORT_CYCLES);
	localparam logic [7:0] LIM_SLOW = 8'(pssr_pkg::STEP_SLOW - 1);
	localparam logic [7:0] LIM_FAST = 8'(pssr_pkg::STEP_FAST - 1);

	typedef struct packed {
		logic [15:0] sh;
		logic [15:0] tx;
		logic tog;
		logic miso;
	} pssr_dev_link_t;

	typedef struct packed {
		logic [2:0] tog;
		logic [pssr_pkg::DET_W-1:0] d1;
		logic [pssr_pkg::DET_W-1:0] d2;
		logic [1:0] ro;
		logic ro_seen;
		logic [7:0] duty;
		logic [7:0] freq;
		logic [7:0] scratch;
		logic [7:0] fb;
		logic [7:0] fa;
		logic [7:0] th;
		logic [CW-1:0] short_cnt;
		logic uv_prev;
		logic thermal_shutdown_level_two_prev;
		logic [2:0] uv_resets;
		logic [15:0] rsp;
		logic [1:0][7:0] pre;
		logic [1:0][7:0] step;
		logic [1:0] pwm;
		logic fs;
	} pssr_dev_state_t;

	pssr_dev_link_t l_r;
	pssr_dev_link_t l_nxt;
	pssr_dev_state_t c_r;
	pssr_dev_state_t c_nxt;
	logic [3:0] cnt_r;

	////////////////////////////////////////////////////////////////////////
	// Link domain: bit position, cleared whenever select is high
	always_ff @(posedge link.sck or negedge resetn_i or posedge link.csn) begin
		if (!resetn_i) begin
			cnt_r <= pssr_pkg::FRAME_FIRST;
		end else if (link.csn) begin
			cnt_r <= pssr_pkg::FRAME_FIRST;
		end else begin
			cnt_r <= cnt_r + 4'h1;
		end
	end

	always_comb begin
		l_nxt = l_r;
		l_nxt.sh = {link.mosi, l_r.sh[15:1]};
		if (cnt_r == pssr_pkg::FRAME_FIRST) begin
			l_nxt.tx = c_r.rsp;
			l_nxt.miso = c_r.rsp[0];
		end else begin
			l_nxt.miso = l_r.tx[cnt_r];
		end
		if (cnt_r == pssr_pkg::FRAME_LAST) begin
			l_nxt.tog = ~l_r.tog;
		end
	end

	always_ff @(posedge link.sck or negedge resetn_i) begin
		if (!resetn_i) begin
			l_r <= '0;
		end else begin
			l_r <= l_nxt;
		end
	end

	assign link.miso = l_r.miso;

	////////////////////////////////////////////////////////////////////////
	// Core domain
	always_comb begin
		logic cmd;
		logic clr;
		logic [6:0] ad;
		logic [7:0] dat;
		logic [7:0] rdv;
		logic [pssr_pkg::DET_W-1:0] d;
		logic normal;
		logic blk;
		logic shrt;
		logic uv_ok;
		logic fast;
		logic [7:0] dc;
		logic [7:0] lim;
		cmd = c_r.tog[2] ^ c_r.tog[1];
		clr = l_r.sh[pssr_pkg::MODE_BIT];
		ad = l_r.sh[pssr_pkg::ADDR_W-1:0];
		dat = l_r.sh[15:pssr_pkg::DATA_LSB];
		d = c_r.d2;
		normal = (dev_mode_i == pssr_pkg::MODE_NORMAL);
		rdv = pssr_pkg::ZERO_BYTE;
		fast = 1'b0;
		dc = pssr_pkg::ZERO_BYTE;
		lim = LIM_SLOW;
		blk = 1'b0;
		shrt = 1'b0;
		uv_ok = 1'b0;
		c_nxt = c_r;
		c_nxt.fs = 1'b0;

		// Synchronisers
		c_nxt.tog = {c_r.tog[1:0], l_r.tog};
		c_nxt.d1 = detect_i;
		c_nxt.d2 = c_r.d1;
		c_nxt.ro = {c_r.ro[0], reset_output_pin_i};
		if (c_r.ro[1]) begin
			c_nxt.ro_seen = 1'b1;
		end

		// Read mux
		case (ad)
			pssr_pkg::ADDR_PWM2_DUTY: rdv = c_r.duty;
			pssr_pkg::ADDR_FREQ: rdv = c_r.freq;
			pssr_pkg::ADDR_SCRATCH: rdv = normal ? c_r.scratch : pssr_pkg::ZERO_BYTE;
			pssr_pkg::ADDR_FLAGS_B: rdv = c_r.fb;
			pssr_pkg::ADDR_FLAGS_A: rdv = c_r.fa;
			pssr_pkg::ADDR_THERM: rdv = c_r.th;
			default: rdv = pssr_pkg::ZERO_BYTE;
		endcase

		// Command: write control byte or clear status byte
		if (cmd) begin
			c_nxt.rsp = {rdv, clr, ad};
			if (clr) begin
				case (ad)
					pssr_pkg::ADDR_PWM2_DUTY: c_nxt.duty = dat;
					pssr_pkg::ADDR_FREQ: c_nxt.freq = dat & pssr_pkg::MASK_FREQ;
					pssr_pkg::ADDR_SCRATCH: begin
						if (normal) begin
							c_nxt.scratch = dat;
						end
					end
					pssr_pkg::ADDR_FLAGS_B: c_nxt.fb = pssr_pkg::ZERO_BYTE;
					pssr_pkg::ADDR_FLAGS_A: c_nxt.fa = pssr_pkg::ZERO_BYTE;
					pssr_pkg::ADDR_THERM: c_nxt.th = pssr_pkg::ZERO_BYTE;
					default: ;
				endcase
			end
		end

		// Soft reset keeps the scratch byte
		if (soft_reset_i) begin
			c_nxt.duty = pssr_pkg::RST_PWM2;
			c_nxt.freq = pssr_pkg::RST_FREQ;
			c_nxt.fb = pssr_pkg::RST_FLAGS_B;
			c_nxt.fa = pssr_pkg::SOFT_FLAGS_A;
			c_nxt.th = pssr_pkg::RST_THERM;
			c_nxt.uv_resets = 3'h0;
		end

		// Main regulator short timer
		if (main_on_i && d[pssr_pkg::D_V1_UV]) begin
			if (c_r.short_cnt != SHORT_LIM) begin
				c_nxt.short_cnt = c_r.short_cnt + CW'(1);
			end
		end else begin
			c_nxt.short_cnt = '0;
		end
		shrt = (c_r.short_cnt == SHORT_LIM);
		blk = (dev_mode_i == pssr_pkg::MODE_SLEEP) && !main_on_i;
		uv_ok = shrt || normal || (dev_mode_i == pssr_pkg::MODE_STOP) ||
			((dev_mode_i == pssr_pkg::MODE_INIT) && c_r.ro_seen);

		// Sticky flag setting, set wins over clear
		c_nxt.fb[pssr_pkg::FB_BATTERY_UNDERVOLTAGE_FLAG] |= d[pssr_pkg::D_BATTERY_UNDERVOLTAGE_FLAG];
		c_nxt.fb[pssr_pkg::FB_V3_OC] |= d[pssr_pkg::D_V3_OC];
		c_nxt.fb[pssr_pkg::FB_V3_UV] |= d[pssr_pkg::D_V3_UV];
		c_nxt.fb[pssr_pkg::FB_V3_OT] |= d[pssr_pkg::D_V3_OT];
		c_nxt.fb[pssr_pkg::FB_V1_OV] |= d[pssr_pkg::D_V1_OV] & ~blk;
		c_nxt.fb[pssr_pkg::FB_V1_WARN] |= d[pssr_pkg::D_V1_WARN];
		c_nxt.fa[pssr_pkg::FA_HS_UV] |= d[pssr_pkg::D_HS_UV];
		c_nxt.fa[pssr_pkg::FA_HS_OV] |= d[pssr_pkg::D_HS_OV];
		c_nxt.fa[pssr_pkg::FA_V2_OT] |= d[pssr_pkg::D_V2_OT];
		c_nxt.fa[pssr_pkg::FA_V2_UV] |= d[pssr_pkg::D_V2_UV];
		c_nxt.fa[pssr_pkg::FA_V1_SC] |= shrt & ~blk;
		c_nxt.fa[pssr_pkg::FA_V1_UV] |= d[pssr_pkg::D_V1_UV] & uv_ok & ~blk;
		c_nxt.th[pssr_pkg::TH_THERMAL_SHUTDOWN_LEVEL_TWO] |= d[pssr_pkg::D_THERMAL_SHUTDOWN_LEVEL_TWO];
		c_nxt.th[pssr_pkg::TH_THERMAL_SHUTDOWN_LEVEL_ONE] |= d[pssr_pkg::D_THERMAL_SHUTDOWN_LEVEL_ONE];
		c_nxt.th[pssr_pkg::TH_TPW] |= d[pssr_pkg::D_TPW];

		// Consecutive undervoltage resets
		c_nxt.uv_prev = d[pssr_pkg::D_V1_UV];
		if (d[pssr_pkg::D_V1_UV] && !c_r.uv_prev) begin
			if (c_r.uv_resets == pssr_pkg::UV_RESET_LIMIT - 3'h1) begin
				c_nxt.uv_resets = 3'h0;
				c_nxt.fa[pssr_pkg::FA_V1_FS] = 1'b1;
				c_nxt.fs = 1'b1;
			end else begin
				c_nxt.uv_resets = c_r.uv_resets + 3'h1;
			end
		end else if (normal && !d[pssr_pkg::D_V1_UV]) begin
			c_nxt.uv_resets = 3'h0;
		end

		// Second level thermal shutdown forces fail-safe
		c_nxt.thermal_shutdown_level_two_prev = d[pssr_pkg::D_THERMAL_SHUTDOWN_LEVEL_TWO];
		if (d[pssr_pkg::D_THERMAL_SHUTDOWN_LEVEL_TWO] && !c_r.thermal_shutdown_level_two_prev) begin
			c_nxt.fs = 1'b1;
		end

		// PWM generators; restart mode leaves their settings alone
		for (int i = 0; i < 2; i++) begin
			fast = (i == 0) ? c_r.freq[pssr_pkg::FREQ_CH1_BIT] :
				c_r.freq[pssr_pkg::FREQ_CH2_BIT];
			dc = (i == 0) ? pwm_one_duty_i : c_r.duty;
			lim = fast ? LIM_FAST : LIM_SLOW;
			if (c_r.pre[i] >= lim) begin
				c_nxt.pre[i] = 8'h00;
				c_nxt.step[i] = (c_r.step[i] == pssr_pkg::STEP_LAST) ?
					8'h00 : c_r.step[i] + 8'h01;
			end else begin
				c_nxt.pre[i] = c_r.pre[i] + 8'h01;
			end
			c_nxt.pwm[i] = (c_r.step[i] < dc);
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			c_r <= '0;
			c_r.fa <= pssr_pkg::RST_FLAGS_A;
		end else begin
			c_r <= c_nxt;
		end
	end

	assign pwm_o = c_r.pwm;
	assign failsafe_o = c_r.fs;

endmodule : pssr_dev
`default_nettype wire

// ==== pssr_pkg.sv ====
// Shared constants and types for the PWM and supply status register bank
package pssr_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register addresses
	localparam logic [6:0] ADDR_PWM2_DUTY = 7'h19;
	localparam logic [6:0] ADDR_FREQ = 7'h1C;
	localparam logic [6:0] ADDR_SCRATCH = 7'h1E;
	localparam logic [6:0] ADDR_FLAGS_B = 7'h40;
	localparam logic [6:0] ADDR_FLAGS_A = 7'h41;
	localparam logic [6:0] ADDR_THERM = 7'h42;

	////////////////////////////////////////////////////////////////////////
	// Reset values and writable masks
	localparam logic [7:0] RST_PWM2 = 8'h00;
	localparam logic [7:0] RST_FREQ = 8'h00;
	localparam logic [7:0] RST_SCRATCH = 8'h00;
	localparam logic [7:0] RST_FLAGS_B = 8'h00;
	localparam logic [7:0] RST_FLAGS_A = 8'h80;
	localparam logic [7:0] SOFT_FLAGS_A = 8'h00;
	localparam logic [7:0] RST_THERM = 8'h00;
	localparam logic [7:0] MASK_FREQ = 8'h05;
	localparam logic [7:0] ZERO_BYTE = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int FREQ_CH1_BIT = 0;
	localparam int FREQ_CH2_BIT = 2;
	localparam int FB_BATTERY_UNDERVOLTAGE_FLAG = 6;
	localparam int FB_V3_OC = 4;
	localparam int FB_V3_UV = 3;
	localparam int FB_V3_OT = 2;
	localparam int FB_V1_OV = 1;
	localparam int FB_V1_WARN = 0;
	localparam int FA_HS_UV = 6;
	localparam int FA_HS_OV = 5;
	localparam int FA_V2_OT = 4;
	localparam int FA_V2_UV = 3;
	localparam int FA_V1_SC = 2;
	localparam int FA_V1_FS = 1;
	localparam int FA_V1_UV = 0;
	localparam int TH_THERMAL_SHUTDOWN_LEVEL_TWO = 2;
	localparam int TH_THERMAL_SHUTDOWN_LEVEL_ONE = 1;
	localparam int TH_TPW = 0;

	////////////////////////////////////////////////////////////////////////
	// Detector input vector layout
	localparam int DET_W = 14;
	localparam int D_BATTERY_UNDERVOLTAGE_FLAG = 0;
	localparam int D_V3_OC = 1;
	localparam int D_V3_UV = 2;
	localparam int D_V3_OT = 3;
	localparam int D_V1_OV = 4;
	localparam int D_V1_WARN = 5;
	localparam int D_HS_UV = 6;
	localparam int D_HS_OV = 7;
	localparam int D_V2_OT = 8;
	localparam int D_V2_UV = 9;
	localparam int D_V1_UV = 10;
	localparam int D_THERMAL_SHUTDOWN_LEVEL_TWO = 11;
	localparam int D_THERMAL_SHUTDOWN_LEVEL_ONE = 12;
	localparam int D_TPW = 13;

	////////////////////////////////////////////////////////////////////////
	// Frame layout
	localparam int ADDR_W = 7;
	localparam int MODE_BIT = 7;
	localparam int DATA_LSB = 8;
	localparam logic [3:0] FRAME_FIRST = 4'h0;
	localparam logic [3:0] FRAME_LAST = 4'hF;

	////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_HZ = 10_000_000;
	localparam int SHORT_TIME_MS = 4;
	localparam int SHORT_CYCLES = (CLK_HZ / 1000) * SHORT_TIME_MS;
	localparam int PWM_SLOW_HZ = 200;
	localparam int PWM_FAST_HZ = 400;
	localparam int PWM_STEPS = 255;
	localparam int STEP_SLOW = CLK_HZ / (PWM_SLOW_HZ * PWM_STEPS);
	localparam int STEP_FAST = CLK_HZ / (PWM_FAST_HZ * PWM_STEPS);
	localparam logic [7:0] STEP_LAST = 8'hFE;
	localparam logic [2:0] UV_RESET_LIMIT = 3'h4;
	localparam int LINK_HALF = 3;
	localparam int FRAME_GAP = 16;

	////////////////////////////////////////////////////////////////////////
	// Device operating modes
	typedef enum logic [5:0] {
		MODE_NORMAL = 6'h01,
		MODE_STOP = 6'h02,
		MODE_SLEEP = 6'h04,
		MODE_INIT = 6'h08,
		MODE_RESTART = 6'h10,
		MODE_FAILSAFE = 6'h20
	} pssr_mode_t;

endpackage : pssr_pkg

// ==== pssr_link_if.sv ====
// Serial link between the register bank and its controller
`timescale 1ns/10ps
`default_nettype none
interface pssr_link_if;
	logic sck;
	logic csn;
	logic mosi;
	logic miso;
	modport host(output sck, output csn, output mosi, input miso);
	modport dev(input sck, input csn, input mosi, output miso);
endinterface : pssr_link_if
`default_nettype wire

// ==== pssr_host.sv ====
// Controller end: issues 16-bit frames to the register bank
`timescale 1ns/10ps
`default_nettype none
module pssr_host #(
	parameter int LINK_HALF = pssr_pkg::LINK_HALF,
	parameter int FRAME_GAP = pssr_pkg::FRAME_GAP
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	pssr_link_if.host link,
	input wire logic cmd_valid_i,
	input wire logic [6:0] cmd_addr_i,
	input wire logic cmd_clear_i,
	input wire logic [7:0] cmd_data_i,
	output logic cmd_ready_o,
	output logic rsp_valid_o,
	output logic [15:0] rsp_word_o
);

	localparam logic [7:0] HALF_LD = 8'(LINK_HALF - 1);
	localparam logic [7:0] GAP_LD = 8'(FRAME_GAP - 1);

	typedef enum logic [3:0] {
		H_IDLE = 4'h1,
		H_LOW = 4'h2,
		H_HIGH = 4'h4,
		H_GAP = 4'h8
	} pssr_host_st_t;

	typedef struct packed {
		pssr_host_st_t st;
		logic [7:0] tmr;
		logic [3:0] bitn;
		logic [15:0] tx;
		logic [15:0] rx;
		logic [1:0] m;
		logic sck;
		logic csn;
		logic mosi;
		logic ready;
		logic rvalid;
		logic [15:0] rword;
	} pssr_host_state_t;

	pssr_host_state_t h_r;
	pssr_host_state_t h_nxt;

	////////////////////////////////////////////////////////////////////////
	// Frame sequencer
	always_comb begin
		h_nxt = h_r;
		h_nxt.m = {h_r.m[0], link.miso};
		h_nxt.rvalid = 1'b0;
		case (h_r.st)
			H_IDLE: begin
				if (cmd_valid_i && h_r.ready) begin
					h_nxt.tx = {cmd_data_i, cmd_clear_i, cmd_addr_i};
					h_nxt.mosi = cmd_addr_i[0];
					h_nxt.csn = 1'b0;
					h_nxt.bitn = pssr_pkg::FRAME_FIRST;
					h_nxt.tmr = HALF_LD;
					h_nxt.ready = 1'b0;
					h_nxt.st = H_LOW;
				end
			end
			H_LOW: begin
				if (h_r.tmr == 8'h00) begin
					h_nxt.sck = 1'b1;
					h_nxt.tmr = HALF_LD;
					h_nxt.st = H_HIGH;
				end else begin
					h_nxt.tmr = h_r.tmr - 8'h01;
				end
			end
			H_HIGH: begin
				if (h_r.tmr == 8'h00) begin
					h_nxt.rx[h_r.bitn] = h_r.m[1];
					h_nxt.sck = 1'b0;
					if (h_r.bitn == pssr_pkg::FRAME_LAST) begin
						h_nxt.csn = 1'b1;
						h_nxt.tmr = GAP_LD;
						h_nxt.st = H_GAP;
					end else begin
						h_nxt.bitn = h_r.bitn + 4'h1;
						h_nxt.mosi = h_r.tx[h_r.bitn + 4'h1];
						h_nxt.tmr = HALF_LD;
						h_nxt.st = H_LOW;
					end
				end else begin
					h_nxt.tmr = h_r.tmr - 8'h01;
				end
			end
			H_GAP: begin
				if (h_r.tmr == 8'h00) begin
					h_nxt.rvalid = 1'b1;
					h_nxt.rword = h_r.rx;
					h_nxt.ready = 1'b1;
					h_nxt.st = H_IDLE;
				end else begin
					h_nxt.tmr = h_r.tmr - 8'h01;
				end
			end
			default: h_nxt.st = H_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			h_r <= '0;
			h_r.st <= H_IDLE;
			h_r.csn <= 1'b1;
			h_r.ready <= 1'b1;
		end else begin
			h_r <= h_nxt;
		end
	end

	assign link.sck = h_r.sck;
	assign link.csn = h_r.csn;
	assign link.mosi = h_r.mosi;
	assign cmd_ready_o = h_r.ready;
	assign rsp_valid_o = h_r.rvalid;
	assign rsp_word_o = h_r.rword;

endmodule : pssr_host
`default_nettype wire

// ==== pssr_assertions.sv ====
// Link protocol assertions for the register bank serial link
`timescale 1ns/10ps
`default_nettype none
module pssr_assertions (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic sck,
	input wire logic csn,
	input wire logic mosi,
	input wire logic miso
);
	logic sck_r;
	logic [4:0] edges_r;

	////////////////////////////////////////////////////////////////////////
	// Rising link clock edges counted per frame
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sck_r <= 1'b0;
			edges_r <= 5'h00;
		end else begin
			sck_r <= sck;
			if (csn)
				edges_r <= 5'h00;
			else if (sck && !sck_r)
				edges_r <= edges_r + 5'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Wire checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);

	a_sck_idle_low: assert property (csn |-> !sck)
		else $error("link clock active outside a frame");
	a_frame_length: assert property ($rose(csn) |-> edges_r == 5'h10)
		else $error("frame without exactly sixteen clock edges");
	a_first_edge: assert property ($fell(csn) |-> !sck[*2] ##[1:3] sck)
		else $error("first link clock edge out of place");
	a_sck_high_time: assert property ($rose(sck) |-> sck[*2] ##[1:2] !sck)
		else $error("link clock high time wrong");
	a_mosi_stable: assert property ((sck && $past(sck)) |-> $stable(mosi))
		else $error("host data changed while link clock high");
	a_miso_stable: assert property ((!csn && !$past(csn) && !sck) |-> $stable(miso))
		else $error("device data changed without a rising edge");
	a_csn_gap: assert property ($rose(csn) |-> csn[*8])
		else $error("frame gap too short");
	a_sck_in_frame: assert property (@(posedge sck) disable iff (!resetn_i) !csn)
		else $error("link clock edge without frame select");

endmodule : pssr_assertions
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking testbench for the register bank and its controller
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic clk_i = 1'b0;
	logic resetn_i;
	logic cmd_valid_i = 1'b0;
	logic [6:0] cmd_addr_i = 7'h00;
	logic cmd_clear_i = 1'b0;
	logic [7:0] cmd_data_i = 8'h00;
	logic cmd_ready_o;
	logic rsp_valid_o;
	logic [15:0] rsp_word_o;
	logic soft_reset_i = 1'b0;
	logic main_on_i = 1'b1;
	logic reset_output_pin_i = 1'b0;
	pssr_pkg::pssr_mode_t dev_mode_i = pssr_pkg::MODE_NORMAL;
	logic [pssr_pkg::DET_W-1:0] detect_i = 14'h0000;
	logic [7:0] pwm_one_duty_i = 8'h00;
	logic [1:0] pwm_o;
	logic failsafe_o;
	logic [31:0] seed = 32'hFBBF;
	logic [15:0] pend = 16'h0000;
	logic [15:0] exp_q[$];
	logic [15:0] frm_q[$];
	logic [15:0] sh;
	int errors = 0;
	int comparisons = 0;
	int cycles = 0;

	////////////////////////////////////////////////////////////////////////
	// Design, link and checker
	pssr_link_if link();
	pssr_host i_pssr_host (.clk_i(clk_i), .resetn_i(resetn_i), .link(link),
		.cmd_valid_i(cmd_valid_i), .cmd_addr_i(cmd_addr_i),
		.cmd_clear_i(cmd_clear_i), .cmd_data_i(cmd_data_i),
		.cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o),
		.rsp_word_o(rsp_word_o));
	pssr_dev #(.SHORT_CYCLES(20)) i_pssr_dev (.clk_i(clk_i),
		.resetn_i(resetn_i), .link(link), .soft_reset_i(soft_reset_i),
		.dev_mode_i(dev_mode_i), .main_on_i(main_on_i),
		.reset_output_pin_i(reset_output_pin_i), .detect_i(detect_i),
		.pwm_one_duty_i(pwm_one_duty_i), .pwm_o(pwm_o),
		.failsafe_o(failsafe_o));
	pssr_assertions i_pssr_assertions (.clk_i(clk_i), .resetn_i(resetn_i),
		.sck(link.sck), .csn(link.csn), .mosi(link.mosi), .miso(link.miso));

	initial begin
		forever #50 clk_i = ~clk_i;
	end

	////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction : rnd

	task automatic end_sim();
		if (errors == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim

	task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %0t word %h expected %h", $time, got, exp);
		end
	endtask : cmp_word

	task automatic cmp_bit(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %0t level %b expected %b", $time, got, exp);
		end
	endtask : cmp_bit

	// One frame; v is the value the device reads back for this address before this command acts
	task automatic xfer(input logic [6:0] a, input logic c,
		input logic [7:0] d, input logic [7:0] v);
		exp_q.push_back(pend);
		frm_q.push_back({d, c, a});
		pend = {v, c, a};
		cmd_addr_i <= a;
		cmd_clear_i <= c;
		cmd_data_i <= d;
		cmd_valid_i <= 1'b1;
		@(posedge clk_i);
		while (cmd_ready_o !== 1'b1) @(posedge clk_i);
		cmd_valid_i <= 1'b0;
		for (int n = 0; n < 200 && rsp_valid_o !== 1'b1; n++) @(posedge clk_i);
	endtask : xfer

	task automatic rd(input logic [6:0] a, input logic [7:0] v);
		xfer(a, 1'b0, rnd(), v);
	endtask : rd

	task automatic chk_pwm(input logic v);
		pwm_one_duty_i <= {8{v}};
		repeat (4) @(posedge clk_i);
		repeat (255) begin
			@(posedge clk_i);
			cmp_bit(pwm_o[1], v);
			cmp_bit(pwm_o[0], v);
		end
	endtask : chk_pwm

	////////////////////////////////////////////////////////////////////////
	// Result watchers and timeout
	always @(posedge clk_i) begin
		if (rsp_valid_o === 1'b1)
			cmp_word(rsp_word_o, exp_q.pop_front());
	end

	always @(posedge link.sck) sh <= {link.mosi, sh[15:1]};

	always @(posedge link.csn) begin
		if (resetn_i === 1'b1 && frm_q.size() > 0)
			cmp_word(sh, frm_q.pop_front());
	end

	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			$display("mismatch %0t timeout", $time);
			end_sim();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic [7:0] d2;
		logic [7:0] sc;
		logic fs;
		resetn_i <= 1'b0;
		repeat (20) @(posedge clk_i);
		resetn_i <= 1'b1;
		@(posedge clk_i);
		rd(pssr_pkg::ADDR_PWM2_DUTY, 8'h00);
		rd(pssr_pkg::ADDR_FREQ, 8'h00);
		rd(pssr_pkg::ADDR_SCRATCH, 8'h00);
		rd(pssr_pkg::ADDR_FLAGS_B, 8'h00);
		rd(pssr_pkg::ADDR_FLAGS_A, 8'h80);
		rd(pssr_pkg::ADDR_THERM, 8'h00);
		rd(7'h20, 8'h00);
		d2 = rnd() | 8'h01;
		sc = rnd();
		pwm_one_duty_i <= rnd();
		xfer(pssr_pkg::ADDR_PWM2_DUTY, 1'b1, d2, 8'h00);
		xfer(pssr_pkg::ADDR_FREQ, 1'b1, 8'hFF, 8'h00);
		xfer(pssr_pkg::ADDR_SCRATCH, 1'b1, sc, 8'h00);
		dev_mode_i <= pssr_pkg::MODE_RESTART;
		rd(pssr_pkg::ADDR_PWM2_DUTY, d2);
		rd(pssr_pkg::ADDR_FREQ, 8'h05);
		dev_mode_i <= pssr_pkg::MODE_STOP;
		xfer(pssr_pkg::ADDR_SCRATCH, 1'b1, 8'h5A, 8'h00);
		dev_mode_i <= pssr_pkg::MODE_NORMAL;
		rd(pssr_pkg::ADDR_SCRATCH, sc);
		xfer(pssr_pkg::ADDR_PWM2_DUTY, 1'b1, 8'hFF, d2);
		chk_pwm(1'b1);
		xfer(pssr_pkg::ADDR_PWM2_DUTY, 1'b1, 8'h00, 8'hFF);
		chk_pwm(1'b0);
		xfer(pssr_pkg::ADDR_PWM2_DUTY, 1'b1, d2, 8'h00);
		soft_reset_i <= 1'b1;
		@(posedge clk_i);
		soft_reset_i <= 1'b0;
		rd(pssr_pkg::ADDR_PWM2_DUTY, 8'h00);
		rd(pssr_pkg::ADDR_FREQ, 8'h00);
		rd(pssr_pkg::ADDR_FLAGS_A, 8'h00);
		rd(pssr_pkg::ADDR_SCRATCH, sc);
		detect_i <= 14'h3BFF;
		fs = 1'b0;
		repeat (8) begin
			@(posedge clk_i);
			fs = fs | (failsafe_o === 1'b1);
		end
		cmp_bit(fs, 1'b1);
		detect_i <= 14'h0000;
		rd(pssr_pkg::ADDR_FLAGS_B, 8'h5F);
		rd(pssr_pkg::ADDR_FLAGS_A, 8'h78);
		rd(pssr_pkg::ADDR_THERM, 8'h07);
		xfer(pssr_pkg::ADDR_FLAGS_B, 1'b1, rnd(), 8'h5F);
		xfer(pssr_pkg::ADDR_FLAGS_A, 1'b1, rnd(), 8'h78);
		xfer(pssr_pkg::ADDR_THERM, 1'b1, rnd(), 8'h07);
		rd(pssr_pkg::ADDR_FLAGS_B, 8'h00);
		rd(pssr_pkg::ADDR_FLAGS_A, 8'h00);
		rd(pssr_pkg::ADDR_THERM, 8'h00);
		// Sleep with regulator off, then init before reset pin release
		main_on_i <= 1'b0;
		dev_mode_i <= pssr_pkg::MODE_SLEEP;
		detect_i <= 14'h0410;
		repeat (8) @(posedge clk_i);
		detect_i <= 14'h0400;
		repeat (4) @(posedge clk_i);
		main_on_i <= 1'b1;
		dev_mode_i <= pssr_pkg::MODE_INIT;
		repeat (8) @(posedge clk_i);
		detect_i <= 14'h0000;
		repeat (4) @(posedge clk_i);
		dev_mode_i <= pssr_pkg::MODE_NORMAL;
		reset_output_pin_i <= 1'b1;
		rd(pssr_pkg::ADDR_FLAGS_B, 8'h00);
		rd(pssr_pkg::ADDR_FLAGS_A, 8'h00);
		// Four undervoltage resets in restart, then a short
		dev_mode_i <= pssr_pkg::MODE_RESTART;
		fs = 1'b0;
		for (int n = 0; n < 40; n++) begin
			detect_i <= (n[2] && n < 32) ? 14'h0400 : 14'h0000;
			@(posedge clk_i);
			fs = fs | (failsafe_o === 1'b1);
		end
		cmp_bit(fs, 1'b1);
		rd(pssr_pkg::ADDR_FLAGS_A, 8'h02);
		detect_i <= 14'h0400;
		repeat (30) @(posedge clk_i);
		detect_i <= 14'h0000;
		repeat (4) @(posedge clk_i);
		dev_mode_i <= pssr_pkg::MODE_NORMAL;
		rd(pssr_pkg::ADDR_FLAGS_A, 8'h07);
		rd(pssr_pkg::ADDR_PWM2_DUTY, 8'h00);
		@(posedge clk_i);
		cmp_word(16'(exp_q.size()), 16'h0000);
		end_sim();
	end

endmodule : tb_top
`default_nettype wire
